/* File: odtc_defines.svh */
`ifndef ODTC_DEFINES_SVH
`define ODTC_DEFINES_SVH

// Clock rate and the protection time base of one millisecond.
`define ODTC_CLK_HZ 20000000
`define ODTC_TICK_MS 1
`define ODTC_TICK_CYCLES (`ODTC_CLK_HZ / 1000 * `ODTC_TICK_MS)

// Register byte offsets.
`define ODTC_A_SDPICK 8'h00
`define ODTC_A_SDDLY 8'h04
`define ODTC_A_INST 8'h08
`define ODTC_A_REPICK 8'h0c
`define ODTC_A_OPT 8'h10
`define ODTC_A_CMD 8'h14
`define ODTC_A_STAT 8'h18

// Field positions.
`define ODTC_F_PICK 4:0
`define ODTC_F_BAND 3:0
`define ODTC_F_SLOPE 5:4
`define ODTC_F_HALF 5:0
`define ODTC_F_OPT 10:0
`define ODTC_O_VAR 1:0
`define ODTC_O_EXT 2
`define ODTC_O_HIGH 3
`define ODTC_O_SDOPT 4
`define ODTC_O_SWI 5
`define ODTC_O_RE 6
`define ODTC_O_FUSE 7
`define ODTC_O_F50 8
`define ODTC_O_FRAME 10:9
`define ODTC_C_ENG 0
`define ODTC_C_DIS 1
`define ODTC_C_CLRT 2
`define ODTC_C_CLRR 3
`define ODTC_S_ENG 0
`define ODTC_S_REM 1
`define ODTC_S_HOLD 2
`define ODTC_S_SDON 3
`define ODTC_S_TRIP 4
`define ODTC_S_REF 5
`define ODTC_S_CAUSE 8:6

// Reset values.
`define ODTC_RST_PICK 5'h06
`define ODTC_RST_BAND 4'h1
`define ODTC_RST_SLOPE 2'h0
`define ODTC_RST_INST 6'h14
`define ODTC_RST_REPICK 6'h06
`define ODTC_RST_OPT 11'h050

// Setting limits, in half multiples, and the highest band number.
`define ODTC_PICK_MIN 5'h03
`define ODTC_SDMAX_V0 5'h18
`define ODTC_SDMAX_V1 5'h14
`define ODTC_SDMAX_V2 5'h12
`define ODTC_SDMAX_V3 5'h0e
`define ODTC_BAND_MAX 4'hb
`define ODTC_INST_MIN 6'h04
`define ODTC_INST_STD 6'h1e
`define ODTC_INST_EXT 6'h3c
`define ODTC_IMAX_F0_SD 6'h1e
`define ODTC_IMAX_F1_SD 6'h1a
`define ODTC_IMAX_NOSD 6'h14
`define ODTC_IMAX_F2 6'h12
`define ODTC_IMAX_F3 6'h0e
`define ODTC_RE_MIN 6'h03

// Short-delay band commit times in ms, 60 Hz then 50 Hz.
`define ODTC_B1_60 16'h0019
`define ODTC_B2_60 16'h0021
`define ODTC_B3_60 16'h002a
`define ODTC_B4_60 16'h003a
`define ODTC_B5_60 16'h005c
`define ODTC_B6_60 16'h0075
`define ODTC_B7_60 16'h009e
`define ODTC_B8_60 16'h00b7
`define ODTC_B9_60 16'h00d9
`define ODTC_B10_60 16'h015e
`define ODTC_B11_60 16'h01a1
`define ODTC_B1_50 16'h001e
`define ODTC_B2_50 16'h0028
`define ODTC_B3_50 16'h0032
`define ODTC_B4_50 16'h003c
`define ODTC_B5_50 16'h006e
`define ODTC_B6_50 16'h0082
`define ODTC_B7_50 16'h00b4
`define ODTC_B8_50 16'h00d2
`define ODTC_B9_50 16'h00f0
`define ODTC_B10_50 16'h0118
`define ODTC_B11_50 16'h0154

// Clearing times, hold time and flash half period in ms.
`define ODTC_RE_CLR_60 16'h002a
`define ODTC_RE_CLR_50 16'h0032
`define ODTC_INST_CLR_60 16'h0032
`define ODTC_INST_CLR_50 16'h003c
`define ODTC_HOLD_MS 16'h3a98
`define ODTC_FLASH_MS 16'h00fa

// Inverse-square energy thresholds for slopes 1 to 3, in half-multiple squared ms.
`define ODTC_K_SLOPE1 24'h009c40
`define ODTC_K_SLOPE2 24'h013880
`define ODTC_K_SLOPE3 24'h027100

`endif

/* File: odtc_pkg.sv */
package odtc_pkg;

  typedef enum logic [1:0] {
    ODTC_RE_OFF = 2'b00,
    ODTC_RE_ON = 2'b01,
    ODTC_RE_HOLD = 2'b10
  } odtc_re_state_t;

  typedef struct packed {
    logic ready;
    logic resp;
    logic [31:0] rdata;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [4:0] sd_pick;
    logic [3:0] sd_band;
    logic [1:0] sd_slope;
    logic [5:0] inst;
    logic [5:0] re_pick;
    logic [10:0] opt;
    logic remote_req;
    odtc_re_state_t re_state;
    logic [15:0] hold_ms;
    logic [15:0] tick_cnt;
    logic tick;
    logic [15:0] sd_ms;
    logic [23:0] sd_heat;
    logic [15:0] inst_ms;
    logic [15:0] re_ms;
    logic trip;
    logic [2:0] cause;
    logic refused;
    logic [15:0] flash_ms;
    logic flash;
    logic re_out;
    logic sd_on;
  } odtc_state_t;

endpackage : odtc_pkg

/* File: odtc_top.sv */
// Notes on behaviour
// RULE1: Short-delay pickup is OFF or 1.5 up in 0.5 steps, capped per variant.
// RULE2: Short-delay timing combines slope OFF/1/2/3 with one of 11 fixed bands.
// RULE3: Band OFF disables short delay, but not while undelayed element is OFF.
// RULE4: Slope OFF uses band only; slopes add inverse-square delay, band governs beyond.
// RULE5: Band commit times follow the table per line frequency.
// RULE6: Fuse-shaped long-delay curve forces short-delay slope OFF.
// RULE7: Undelayed pickup 2.0 to 15 in 0.5 steps, 15 to 30 in steps of 1.
// RULE8: Undelayed pickup above 15 needs the extended-range option.
// RULE9: High-range option above 15 forces short delay on, hidden at maximum if absent.
// RULE10: Undelayed maximum depends on frame and on short delay being enabled.
// RULE11: Undelayed OFF only when switchable and the short-delay band is not OFF.
// RULE12: Reduced-energy pickup 1.5 upward in 0.5 steps to 15 or undelayed maximum.
// RULE13: Reduced-energy mode works even with undelayed element OFF.
// RULE14: Reduced-energy pickup exceeded clears the fault within 50 ms.
// RULE15: Reduced-energy clears in 42/50 ms, undelayed in 50/60 ms at 60/50 Hz.
// RULE16: With the option fitted, input 1 triggers and output 1 indicates the mode.
// RULE17: The indicator output is on for the whole time the mode is engaged.
// RULE18: Separate remote commands engage and disengage; status is readable.
// RULE19: The display warning flashes while the mode is engaged.
// RULE20: Mode stays on until all triggers clear, then 15 s more.
// RULE21: No front-panel path can engage or disengage the mode.
// RULE22: A trigger during the hold keeps the mode on and restarts the hold later.
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`include "odtc_defines.svh"

module odtc_top #(
  parameter int TICK_CYCLES = `ODTC_TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] sd_current,
  input wire logic [7:0] rated_current,
  input wire logic re_input,
  output logic trip_out,
  output logic re_indicator,
  output logic display_warn,
  output logic sd_active
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  odtc_pkg::odtc_state_t s;
  odtc_pkg::odtc_state_t n;

  // Largest short-delay pickup for each breaker variant.
  function automatic logic [4:0] sd_max(input logic [1:0] variant);
    unique case (variant)
      2'b00: sd_max = `ODTC_SDMAX_V0;
      2'b01: sd_max = `ODTC_SDMAX_V1;
      2'b10: sd_max = `ODTC_SDMAX_V2;
      2'b11: sd_max = `ODTC_SDMAX_V3;
    endcase
  endfunction : sd_max

  // Largest undelayed pickup for a frame class, with or without short delay.
  function automatic logic [5:0] inst_max(input logic [1:0] frame, input logic sd_on, input logic ext);
    logic [5:0] m;
    unique case (frame)
      2'b00: m = sd_on ? `ODTC_IMAX_F0_SD : `ODTC_IMAX_NOSD;
      2'b01: m = sd_on ? `ODTC_IMAX_F1_SD : `ODTC_IMAX_NOSD;
      2'b10: m = `ODTC_IMAX_F2;
      2'b11: m = `ODTC_IMAX_F3;
    endcase
    inst_max = (ext && frame == 2'b00) ? `ODTC_INST_EXT : m;
  endfunction : inst_max

  // Constant-time band commit time in ms.
  function automatic logic [15:0] band_ms(input logic [3:0] band, input logic f50);
    logic [15:0] t;
    unique case (band)
      4'h1: t = f50 ? `ODTC_B1_50 : `ODTC_B1_60;
      4'h2: t = f50 ? `ODTC_B2_50 : `ODTC_B2_60;
      4'h3: t = f50 ? `ODTC_B3_50 : `ODTC_B3_60;
      4'h4: t = f50 ? `ODTC_B4_50 : `ODTC_B4_60;
      4'h5: t = f50 ? `ODTC_B5_50 : `ODTC_B5_60;
      4'h6: t = f50 ? `ODTC_B6_50 : `ODTC_B6_60;
      4'h7: t = f50 ? `ODTC_B7_50 : `ODTC_B7_60;
      4'h8: t = f50 ? `ODTC_B8_50 : `ODTC_B8_60;
      4'h9: t = f50 ? `ODTC_B9_50 : `ODTC_B9_60;
      4'ha: t = f50 ? `ODTC_B10_50 : `ODTC_B10_60;
      default: t = f50 ? `ODTC_B11_50 : `ODTC_B11_60;
    endcase
    band_ms = t;
  endfunction : band_ms

  // Energy threshold of each slope; steeper slopes need more energy.
  function automatic logic [23:0] slope_k(input logic [1:0] slope);
    unique case (slope)
      2'b01: slope_k = `ODTC_K_SLOPE1;
      2'b10: slope_k = `ODTC_K_SLOPE2;
      2'b11: slope_k = `ODTC_K_SLOPE3;
      2'b00: slope_k = '0;
    endcase
  endfunction : slope_k

  // Saturating millisecond increment.
  function automatic logic [15:0] inc16(input logic [15:0] x);
    inc16 = (x == 16'hffff) ? x : x + 16'h0001;
  endfunction : inc16

  logic f50;
  logic sd_user_on;
  logic forced;
  logic hidden;
  logic sd_en;
  logic [4:0] pick_eff;
  logic [3:0] band_eff;
  logic [1:0] slope_eff;
  logic [5:0] imax;
  logic in_sd;
  logic in_inst;
  logic in_re;
  logic trig;
  logic engaged;
  logic [15:0] band_lim;
  logic [15:0] inst_lim;
  logic [15:0] re_lim;
  logic sd_fire;
  logic inst_fire;
  logic re_fire;
  logic addr_ph;
  logic mapped;
  logic [31:0] rd_mux;
  logic [24:0] heat_sum;

  // Effective protection settings after interlocks and forcing.
  assign f50 = s.opt[`ODTC_O_F50];
  assign sd_user_on = (s.sd_band != 4'h0) && (s.sd_pick != 5'h00); // RULE3
  assign forced = s.opt[`ODTC_O_HIGH] && (s.inst > `ODTC_INST_STD); // RULE9
  assign hidden = forced && (!s.opt[`ODTC_O_SDOPT] || !sd_user_on); // RULE9
  assign sd_en = sd_user_on || forced;
  assign pick_eff = hidden ? sd_max(s.opt[`ODTC_O_VAR]) : s.sd_pick;
  assign band_eff = hidden ? `ODTC_BAND_MAX : s.sd_band;
  assign slope_eff = (s.opt[`ODTC_O_FUSE] || hidden) ? 2'b00 : s.sd_slope; // RULE6
  assign imax = inst_max(s.opt[`ODTC_O_FRAME], sd_user_on, s.opt[`ODTC_O_EXT]); // RULE10

  // Pickup detection of the three elements.
  assign in_sd = sd_en && (sd_current >= {3'b000, pick_eff});
  assign in_inst = (s.inst != 6'h00) && (rated_current >= {2'b00, s.inst});
  assign in_re = engaged && (rated_current >= {2'b00, s.re_pick}); // RULE13

  // Only the wired input and the bus command can trigger the mode.
  assign trig = s.opt[`ODTC_O_RE] && (s.remote_req || re_input); // RULE16 RULE21
  assign engaged = s.re_state != odtc_pkg::ODTC_RE_OFF;

  // Trip decisions.
  assign band_lim = band_ms(band_eff, f50); // RULE5
  assign inst_lim = f50 ? `ODTC_INST_CLR_50 : `ODTC_INST_CLR_60; // RULE15
  assign re_lim = f50 ? `ODTC_RE_CLR_50 : `ODTC_RE_CLR_60; // RULE15
  assign sd_fire = in_sd && (s.sd_ms >= band_lim) && ((slope_eff == 2'b00) || (s.sd_heat >= slope_k(slope_eff))); // RULE4 RULE2
  assign inst_fire = in_inst && (s.inst_ms >= inst_lim);
  assign re_fire = in_re && (s.re_ms >= re_lim); // RULE14
  assign heat_sum = {1'b0, s.sd_heat} + {9'h000, 16'(sd_current) * 16'(sd_current)};

  // Bus address phase and read decode.
  assign addr_ph = hsel && htrans[1] && hready;
  assign mapped = haddr[31:8] == 24'h000000;
  always_comb begin
    rd_mux = '0;
    if (mapped) begin
      unique case (haddr[7:0])
        `ODTC_A_SDPICK: rd_mux[`ODTC_F_PICK] = s.sd_pick;
        `ODTC_A_SDDLY: begin
          rd_mux[`ODTC_F_BAND] = s.sd_band;
          rd_mux[`ODTC_F_SLOPE] = s.sd_slope;
        end
        `ODTC_A_INST: rd_mux[`ODTC_F_HALF] = s.inst;
        `ODTC_A_REPICK: rd_mux[`ODTC_F_HALF] = s.re_pick;
        `ODTC_A_OPT: rd_mux[`ODTC_F_OPT] = s.opt;
        `ODTC_A_STAT: begin
          rd_mux[`ODTC_S_ENG] = engaged; // RULE18
          rd_mux[`ODTC_S_REM] = s.remote_req;
          rd_mux[`ODTC_S_HOLD] = s.re_state == odtc_pkg::ODTC_RE_HOLD;
          rd_mux[`ODTC_S_SDON] = s.sd_on;
          rd_mux[`ODTC_S_TRIP] = s.trip;
          rd_mux[`ODTC_S_REF] = s.refused;
          rd_mux[`ODTC_S_CAUSE] = s.cause;
        end
        default: rd_mux = '0;
      endcase
    end
  end

  // Next-state logic of the whole block.
  always_comb begin
    logic [4:0] wpick;
    logic [3:0] wband;
    logic [5:0] whalf;
    logic bad;
    logic clr_trip;
    logic clr_ref;
    logic n_eng;
    wpick = hwdata[`ODTC_F_PICK];
    wband = hwdata[`ODTC_F_BAND];
    whalf = hwdata[`ODTC_F_HALF];
    bad = 1'b0;
    clr_trip = 1'b0;
    clr_ref = 1'b0;
    n = s;
    n.tick = 1'b0;
    n.ready = 1'b1;
    n.resp = 1'b0;
    // Millisecond time base.
    if (s.tick_cnt >= TICK_LAST) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 16'h0001;
    end
    // Address phase capture; read data is ready for the data phase.
    n.dp_wr = addr_ph && hwrite && mapped;
    if (addr_ph) begin
      n.dp_addr = haddr[7:0];
      if (!hwrite) begin
        n.rdata = rd_mux;
      end
    end
    // Data phase writes; illegal settings are refused and leave the register alone.
    if (s.dp_wr) begin
      unique case (s.dp_addr)
        `ODTC_A_SDPICK: begin
          bad = (wpick != 5'h00) && ((wpick < `ODTC_PICK_MIN) || (wpick > sd_max(s.opt[`ODTC_O_VAR]))); // RULE1
          if (!bad) begin
            n.sd_pick = wpick;
          end
        end
        `ODTC_A_SDDLY: begin
          bad = (wband > `ODTC_BAND_MAX) || ((wband == 4'h0) && (s.inst == 6'h00)); // RULE2 RULE3
          if (!bad) begin
            n.sd_band = wband;
            n.sd_slope = hwdata[`ODTC_F_SLOPE];
          end
        end
        `ODTC_A_INST: begin
          if (whalf == 6'h00) begin
            bad = !s.opt[`ODTC_O_SWI] || (s.sd_band == 4'h0); // RULE11
          end else begin
            bad = (whalf < `ODTC_INST_MIN) || (whalf > imax) || // RULE7 RULE10
                  ((whalf > `ODTC_INST_STD) && (!s.opt[`ODTC_O_EXT] || whalf[0])); // RULE8
          end
          if (!bad) begin
            n.inst = whalf;
          end
        end
        `ODTC_A_REPICK: begin
          bad = (whalf < `ODTC_RE_MIN) || (whalf > `ODTC_INST_STD) || (whalf > imax); // RULE12
          if (!bad) begin
            n.re_pick = whalf;
          end
        end
        `ODTC_A_OPT: n.opt = hwdata[`ODTC_F_OPT];
        `ODTC_A_CMD: begin
          if (hwdata[`ODTC_C_DIS]) begin
            n.remote_req = 1'b0; // RULE18
          end
          if (hwdata[`ODTC_C_ENG] && s.opt[`ODTC_O_RE]) begin
            n.remote_req = 1'b1; // RULE18
          end
          clr_trip = hwdata[`ODTC_C_CLRT];
          clr_ref = hwdata[`ODTC_C_CLRR];
        end
        default: bad = 1'b0;
      endcase
    end
    n.refused = (s.refused && !clr_ref) || bad;
    // Short-delay timer and inverse-square energy accumulator.
    if (!in_sd) begin
      n.sd_ms = '0;
      n.sd_heat = '0;
    end else if (s.tick) begin
      n.sd_ms = inc16(s.sd_ms);
      n.sd_heat = heat_sum[24] ? 24'hffffff : heat_sum[23:0]; // RULE4
    end
    // Undelayed and reduced-energy timers stop at their clearing time.
    if (!in_inst) begin
      n.inst_ms = '0;
    end else if (s.tick && (s.inst_ms < inst_lim)) begin
      n.inst_ms = s.inst_ms + 16'h0001;
    end
    if (!in_re) begin
      n.re_ms = '0;
    end else if (s.tick && (s.re_ms < re_lim)) begin
      n.re_ms = s.re_ms + 16'h0001; // RULE14
    end
    // Trip latch; a new trip wins over a clear in the same cycle.
    n.trip = (s.trip && !clr_trip) || sd_fire || inst_fire || re_fire;
    n.cause = (clr_trip ? 3'b000 : s.cause) | {re_fire, inst_fire, sd_fire};
    // Reduced-energy engage, hold and release.
    unique case (s.re_state)
      odtc_pkg::ODTC_RE_OFF: begin
        if (trig) begin
          n.re_state = odtc_pkg::ODTC_RE_ON;
        end
      end
      odtc_pkg::ODTC_RE_ON: begin
        if (!trig) begin
          n.re_state = odtc_pkg::ODTC_RE_HOLD; // RULE20
          n.hold_ms = '0;
        end
      end
      odtc_pkg::ODTC_RE_HOLD: begin
        if (trig) begin
          n.re_state = odtc_pkg::ODTC_RE_ON; // RULE22
          n.hold_ms = '0;
        end else if (s.tick) begin
          if (s.hold_ms >= `ODTC_HOLD_MS - 16'h0001) begin
            n.re_state = odtc_pkg::ODTC_RE_OFF; // RULE20
          end else begin
            n.hold_ms = s.hold_ms + 16'h0001;
          end
        end
      end
      default: n.re_state = odtc_pkg::ODTC_RE_OFF;
    endcase
    n_eng = n.re_state != odtc_pkg::ODTC_RE_OFF;
    n.re_out = n_eng; // RULE17
    // Display warning starts lit and toggles every flash half period.
    if (!n_eng) begin
      n.flash = 1'b0;
      n.flash_ms = '0;
    end else if (!engaged) begin
      n.flash = 1'b1; // RULE19
      n.flash_ms = '0;
    end else if (s.tick) begin
      if (s.flash_ms >= `ODTC_FLASH_MS - 16'h0001) begin
        n.flash_ms = '0;
        n.flash = !s.flash; // RULE19
      end else begin
        n.flash_ms = s.flash_ms + 16'h0001;
      end
    end
    n.sd_on = sd_en;
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ready <= 1'b1;
      s.sd_pick <= `ODTC_RST_PICK;
      s.sd_band <= `ODTC_RST_BAND;
      s.sd_slope <= `ODTC_RST_SLOPE;
      s.inst <= `ODTC_RST_INST;
      s.re_pick <= `ODTC_RST_REPICK;
      s.opt <= `ODTC_RST_OPT;
      s.re_state <= odtc_pkg::ODTC_RE_OFF;
      s.sd_on <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs come straight from the state register.
  assign hreadyout = s.ready;
  assign hresp = s.resp;
  assign hrdata = s.rdata;
  assign trip_out = s.trip;
  assign re_indicator = s.re_out;
  assign display_warn = s.flash;
  assign sd_active = s.sd_on;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sd_pick_range_a: assert property ((s.sd_pick == 5'h00) || // RULE1
    ((s.sd_pick >= `ODTC_PICK_MIN) && (s.sd_pick <= sd_max(s.opt[`ODTC_O_VAR]))))
    else $error("short-delay pickup out of range");
  band_off_guard_a: assert property ((s.dp_wr && (s.dp_addr == `ODTC_A_SDDLY) && // RULE3
    (hwdata[`ODTC_F_BAND] == 4'h0) && (s.inst == 6'h00)) |=> $stable(s.sd_band))
    else $error("band turned off while undelayed element off");
  fuse_slope_off_a: assert property (s.opt[`ODTC_O_FUSE] |-> (slope_eff == 2'b00)) // RULE6
    else $error("slope active with fuse curve");
  inst_range_a: assert property ((s.inst <= `ODTC_INST_STD) || // RULE8
    (s.opt[`ODTC_O_EXT] && !s.inst[0]))
    else $error("extended undelayed setting without option");
  forced_sd_on_a: assert property (forced |=> sd_active) // RULE9
    else $error("short delay not engaged by high range setting");
  re_clear_time_a: assert property (s.re_ms <= `ODTC_RE_CLR_50) // RULE14
    else $error("reduced-energy clearing exceeded 50 ms");
  re_fire_trip_a: assert property (re_fire |=> trip_out) // RULE14
    else $error("reduced-energy fault not tripped");
  indicator_follow_a: assert property (trig |=> re_indicator) // RULE17
    else $error("indicator off while triggered");
  hold_keeps_on_a: assert property (((s.re_state == odtc_pkg::ODTC_RE_HOLD) && !trig && // RULE20
    (s.hold_ms < `ODTC_HOLD_MS - 16'h0001)) |=> re_indicator)
    else $error("mode released before hold time");
  hold_restart_a: assert property (((s.re_state == odtc_pkg::ODTC_RE_HOLD) && trig) |=> // RULE22
    ((s.re_state == odtc_pkg::ODTC_RE_ON) && (s.hold_ms == 16'h0000)))
    else $error("hold not restarted by trigger");
  warn_dark_a: assert property (!engaged && !trig |=> !display_warn) // RULE19
    else $error("warning shown while mode off");

  re_hold_expiry_c: cover property ((s.re_state == odtc_pkg::ODTC_RE_HOLD) ##1 !re_indicator);
  sd_trip_c: cover property (sd_fire ##1 trip_out);
  inst_trip_c: cover property (inst_fire ##1 trip_out);
  refused_write_c: cover property ($rose(s.refused));

endmodule : odtc_top

/* File: odtc_partner.sv */
// Remote bus master and wired trigger contacts on the far side of the block.
module odtc_partner (
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic re_input
);
  timeunit 1ns;
  timeprecision 1ns;

  // Everything starts idle, with the contacts open.
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    re_input = 1'b0;
  end

  // One single word transfer; released write data shows a changing pattern.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask : xfer

  // Closes or opens the wired trigger contact just after an edge.
  task automatic contact(input logic v);
    @(posedge hclk);
    re_input <= v;
  endtask : contact
endmodule : odtc_partner

/* File: test_odtc_top.sv */
module test_odtc_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 4;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, trip_out, re_indicator, display_warn, sd_active, re_input;
  logic [31:0] haddr, hwdata, hrdata, q, lfsr, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] sd_current, rated_current;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  bit seen_hi, seen_lo;
  logic [31:0] opt_tab[5] = '{32'h050, 32'h050, 32'h150, 32'h050, 32'h0d0};
  logic [31:0] dly_tab[5] = '{32'h01, 32'h0b, 32'h0b, 32'h11, 32'h11};
  int ms_tab[5] = '{25, 417, 340, 100, 25};

  odtc_top #(.TICK_CYCLES(TK)) odtc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sd_current(sd_current),
    .rated_current(rated_current), .re_input(re_input), .trip_out(trip_out), .re_indicator(re_indicator),
    .display_warn(display_warn), .sd_active(sd_active));
  odtc_partner odtc_partner_inst (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .re_input(re_input));

  // Free running clock of 50 ns.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Cuts a hang short.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_time(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] t=%0t cycles=%h window=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_time

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    odtc_partner_inst.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    odtc_partner_inst.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk

  // Counts cycles to the trip; a trip may land up to two ticks late.
  task automatic trip_within(input int ms);
    n = 0;
    while (trip_out !== 1'b1 && n < (ms + 3) * TK) begin
      @(posedge hclk);
      n++;
    end
    chk_time(n, (ms - 1) * TK, (ms + 2) * TK);
  endtask : trip_within

  // Waits while the indicator stays on, watching the display warning.
  task automatic hold_wait(input int limit);
    n = 0;
    while (re_indicator === 1'b1 && n < limit) begin
      @(posedge hclk);
      n++;
      seen_hi |= (display_warn === 1'b1);
      seen_lo |= (display_warn === 1'b0);
    end
  endtask : hold_wait

  // Main sequence: reset values, setting limits, trips, then the reduced-energy hold.
  initial begin
    hresetn = 1'b0;
    sd_current = 8'h00;
    rated_current = 8'h00;
    lfsr = 32'h20;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(32'h00, 32'h06);
    rd_chk(32'h04, 32'h01);
    rd_chk(32'h08, 32'h14);
    rd_chk(32'h0c, 32'h06);
    rd_chk(32'h10, 32'h50);
    rd_chk(32'h18, 32'h08);
    rd_chk(32'h100, 32'h0);
    wr(32'h00, 32'h19);
    rd_chk(32'h00, 32'h06);
    wr(32'h00, 32'h18);
    rd_chk(32'h00, 32'h18);
    wr(32'h08, 32'h1f);
    rd_chk(32'h08, 32'h14);
    wr(32'h08, 32'h03);
    rd_chk(32'h08, 32'h14);
    wr(32'h04, 32'h0c);
    rd_chk(32'h04, 32'h01);
    wr(32'h04, 32'h00);
    wr(32'h10, 32'h70);
    wr(32'h08, 32'h00);
    rd_chk(32'h08, 32'h14);
    rd_chk(32'h18, 32'h20);
    chk(sd_active, 1'b0);
    chk(hresp, 1'b0);
    wr(32'h04, 32'h01);
    wr(32'h08, 32'h00);
    rd_chk(32'h08, 32'h00);
    wr(32'h04, 32'h00);
    rd_chk(32'h04, 32'h01);
    wr(32'h14, 32'h08);
    wr(32'h08, 32'h14);
    wr(32'h00, 32'h06);
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      v = 32'h3 + (lfsr % 18);
      rated_current <= {6'h0, lfsr[1:0]};
      wr(32'h0c, v);
      rd_chk(32'h0c, v);
    end
    wr(32'h0c, 32'h1f);
    rd_chk(32'h0c, v);
    wr(32'h0c, 32'h06);
    wr(32'h14, 32'h08);
    rated_current <= 8'h00;
    for (int i = 0; i < 5; i++) begin
      wr(32'h10, opt_tab[i]);
      wr(32'h04, dly_tab[i]);
      sd_current <= 8'h14;
      trip_within(ms_tab[i]);
      sd_current <= 8'h00;
      rd_chk(32'h18, 32'h58);
      wr(32'h14, 32'h04);
    end
    wr(32'h10, 32'h050);
    wr(32'h04, 32'h01);
    rated_current <= 8'h16;
    trip_within(50);
    rated_current <= 8'h00;
    rd_chk(32'h18, 32'h98);
    wr(32'h14, 32'h04);
    // High-range setting above 15 must bring the short-delay element back on.
    wr(32'h00, 32'h00);
    wr(32'h10, 32'h04c);
    chk(sd_active, 1'b0);
    wr(32'h08, 32'h22);
    repeat (2) @(posedge hclk);
    chk(sd_active, 1'b1);
    wr(32'h08, 32'h14);
    wr(32'h00, 32'h06);
    wr(32'h10, 32'h070);
    wr(32'h08, 32'h00);
    wr(32'h14, 32'h01);
    repeat (3) @(posedge hclk);
    chk(re_indicator, 1'b1);
    rd_chk(32'h18, 32'h0b);
    rated_current <= 8'h0a;
    trip_within(42);
    rated_current <= 8'h00;
    rd_chk(32'h18, 32'h11b);
    wr(32'h14, 32'h04);
    odtc_partner_inst.contact(1'b1);
    wr(32'h14, 32'h02);
    rd_chk(32'h18, 32'h09);
    odtc_partner_inst.contact(1'b0);
    hold_wait(10000);
    chk(re_indicator, 1'b1);
    odtc_partner_inst.contact(1'b1);
    repeat (10) @(posedge hclk);
    odtc_partner_inst.contact(1'b0);
    hold_wait(61000);
    chk_time(n, 60000 - 8, 60000 + 16);
    chk({seen_hi, seen_lo}, 2'b11);
    chk(display_warn, 1'b0);
    report_and_stop();
  end
endmodule : test_odtc_top
